// ===== verilog/acrw_params.svh
// Constants for the conversion control register block
`ifndef ACRW_PARAMS_SVH
`define ACRW_PARAMS_SVH
`define ACRW_CTRL_WIDTH     6
`define ACRW_CTRL_RESET     6'h00
`define ACRW_BIT_CHAN2      5
`define ACRW_BIT_CHAN1      4
`define ACRW_BIT_CHAN0      3
`define ACRW_BIT_CONVERT    2
`define ACRW_BIT_STANDBY    1
`define ACRW_BIT_CODING     0
`define ACRW_SERIAL_BITS    6
`define ACRW_CLK_PERIOD_NS  10
`define ACRW_ACQ_TIME_NS    400
`define ACRW_ACQ_CYCLES     ((`ACRW_ACQ_TIME_NS + `ACRW_CLK_PERIOD_NS - 1) / `ACRW_CLK_PERIOD_NS)
`define ACRW_CONV_TIME_NS   1600
`define ACRW_CONV_CYCLES    ((`ACRW_CONV_TIME_NS + `ACRW_CLK_PERIOD_NS - 1) / `ACRW_CLK_PERIOD_NS)
`endif

// ===== verilog/acrw_pkg.sv
// Types for the conversion control register block
package acrw_pkg;
  typedef struct packed {
    logic [2:0] chan_sel;
    logic       soft_convert_bit;
    logic       soft_standby_bit;
    logic       twos_comp;
  } acrw_ctrl_s;

  typedef enum logic [1:0] {
    ACRW_IDLE    = 2'b00,
    ACRW_ACQUIRE = 2'b01,
    ACRW_CONVERT = 2'b10
  } acrw_conv_e;
endpackage

// ===== verilog/acrw_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module acrw_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             mclk,   // System clock
  input  wire logic             rst,    // Synchronous reset
  input  wire logic [WIDTH-1:0] d,      // Asynchronous inputs
  output logic      [WIDTH-1:0] q       // Synchronised outputs
);
  logic [WIDTH-1:0] meta;

  // First stage only feeds the second
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ===== verilog/acrw_ctrl.sv
// Conversion control register with parallel and serial write paths
`timescale 1ns/1ps
`include "acrw_params.svh"
// What this block does
// RQ1 - Six-bit register: three channel bits, soft start, soft standby, coding.
// RQ2 - Parallel and serial writes both load the same register contents.
// RQ3 - Register clears to zero at reset.
// RQ4 - Host gives at least six serial clocks with frame sync low.
// RQ5 - Frame sync rising before six clocks leaves register unchanged.
// RQ6 - Aborted serial write still starts conversion if soft start was one.
// RQ7 - First six data bits taken on falling serial edges; later ones ignored.
// RQ8 - Coding bit one gives two's complement results, zero straight binary.
// RQ9 - Soft start write waits acquisition time before hold and conversion.
// RQ10 - Serial order: channel bits 2,1,0, soft start, standby, coding.
module acrw_ctrl #(
  parameter int ACQ_CYCLES  = `ACRW_ACQ_CYCLES,
  parameter int CONV_CYCLES = `ACRW_CONV_CYCLES
) (
  input  wire logic        mclk,               // System clock
  input  wire logic        rst,                // Synchronous reset
  input  wire logic        chip_sel_n,         // Parallel chip select
  input  wire logic        write_n,            // Parallel write strobe
  input  wire logic [5:0]  par_data,           // Parallel data lines
  input  wire logic        serial_clk,         // Serial clock pin
  input  wire logic        write_frame_sync_n, // Serial write frame
  input  wire logic        serial_din,         // Serial data in
  input  wire logic [11:0] raw_result,         // Offset-binary result in
  output acrw_pkg::acrw_ctrl_s ctrl,           // Control register
  output logic [11:0]      coded_result,       // Result in chosen coding
  output logic             track_hold,         // High while in hold
  output logic             conv_busy,          // Acquisition or conversion running
  output logic             conv_start          // Start pulse, one cycle
);
  logic [2:0]  s_par;   // chip_sel_n, write_n, sclk
  logic [1:0]  s_ser;   // frame, data
  logic [5:0]  s_data;
  logic        par_wr_d;
  logic        sclk_d;
  logic        frame_d;
  logic [5:0]  shift;
  logic [2:0]  bit_cnt;
  logic        par_done;
  logic        sclk_fall;
  logic        frame_rise;
  logic        frame_fall;
  logic        ser_done;
  logic        ser_abort;
  logic        load;
  logic [5:0]  load_val;
  logic        trigger;
  logic        par_active;  // Strobe low on both synced lines
  logic [5:0]  par_latch;   // Data from the last strobe cycle
  logic        bit_take;    // Falling serial edge inside a frame
  logic        acq_done;    // Acquisition delay just expired
  logic [15:0] timer;
  acrw_pkg::acrw_conv_e state;
  acrw_pkg::acrw_conv_e next_state;

  // Pack a raw six-bit word into register fields, first serial bit on top
  function automatic acrw_pkg::acrw_ctrl_s to_ctrl(input logic [5:0] w);
    acrw_pkg::acrw_ctrl_s c;
    c.chan_sel         = {w[`ACRW_BIT_CHAN2], w[`ACRW_BIT_CHAN1],
                          w[`ACRW_BIT_CHAN0]};                   // [RQ10]
    c.soft_convert_bit = w[`ACRW_BIT_CONVERT];
    c.soft_standby_bit = w[`ACRW_BIT_STANDBY];
    c.twos_comp        = w[`ACRW_BIT_CODING];
    return c;
  endfunction

  // True while fewer than six bits have arrived in the frame
  function automatic logic bits_open(input logic [2:0] cnt);
    return cnt < 3'(`ACRW_SERIAL_BITS);
  endfunction

  // Pins cross into mclk through two flops each
  // Serial clock phases under one mclk period will lose edges
  acrw_sync #(.WIDTH(3), .INIT(3'h7)) u_sync_par (
    .mclk (mclk),
    .rst  (rst),
    .d    ({chip_sel_n, write_n, serial_clk}),
    .q    (s_par)
  );
  acrw_sync #(.WIDTH(2), .INIT(2'h2)) u_sync_ser (
    .mclk (mclk),
    .rst  (rst),
    .d    ({write_frame_sync_n, serial_din}),
    .q    (s_ser)
  );
  acrw_sync #(.WIDTH(6), .INIT(6'h00)) u_sync_dat (
    .mclk (mclk),
    .rst  (rst),
    .d    (par_data),
    .q    (s_data)
  );

  // Edge history of synchronised pins
  // Reset values match idle pins, so no false edge follows reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      par_wr_d <= 1'b0;
      sclk_d   <= 1'b1;
      frame_d  <= 1'b1;
    end else begin
      par_wr_d <= par_active;
      sclk_d   <= s_par[0];
      frame_d  <= s_ser[1];
    end
  end

  // Parallel write latches on the rising edge of the strobe
  assign par_active = ~s_par[2] & ~s_par[1];
  assign par_done   = par_wr_d & ~par_active;
  assign sclk_fall  = sclk_d & ~s_par[0];
  assign frame_rise = ~frame_d & s_ser[1];
  assign frame_fall = frame_d & ~s_ser[1];
  assign bit_take   = ~s_ser[1] & sclk_fall;
  // Data sampled by mclk lags the pins equally, so edges stay aligned
  // Only the sixth bit loads; a shorter frame never reaches it
  assign ser_done   = bit_take
                      && bit_cnt == 3'(`ACRW_SERIAL_BITS - 1);  // [RQ5]
  assign ser_abort  = frame_rise && bits_open(bit_cnt);

  // Data is held from inside the strobe, as a host may move the lines
  // in the same instant that it lifts the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      par_latch <= 6'h00;
    end else if (par_active) begin
      par_latch <= s_data;
    end
  end

  // Serial shifter: first six falling edges in the frame only
  always_ff @(posedge mclk) begin
    if (rst) begin
      shift   <= 6'h00;
      bit_cnt <= 3'h0;
    end else if (frame_fall) begin
      bit_cnt <= 3'h0;
    end else if (bit_take && bits_open(bit_cnt)) begin       // [RQ7]
      shift   <= {shift[4:0], s_ser[0]};                     // [RQ10]
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // Either path loads the same fields
  assign load     = par_done | ser_done;                     // [RQ2]
  assign load_val = par_done ? par_latch : {shift[4:0], s_ser[0]};

  // Register loads only from a finished word on either path
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl <= to_ctrl(`ACRW_CTRL_RESET);                     // [RQ3]
    end else if (load) begin
      ctrl <= to_ctrl(load_val);                             // [RQ1]
    end
    // Short frame leaves the register alone [RQ5]
  end

  // Start request: write with soft start, or aborted frame with it held
  // A trigger while converting is dropped; the host waits out busy
  assign trigger = (load && load_val[`ACRW_BIT_CONVERT])     // [RQ9]
                   || (ser_abort && ctrl.soft_convert_bit);  // [RQ6]

  // Acquisition delay, then hold and convert
  // A fresh trigger while acquiring starts the delay over
  always_comb begin
    next_state = state;
    case (state)
      acrw_pkg::ACRW_IDLE:
        if (trigger) next_state = acrw_pkg::ACRW_ACQUIRE;
      acrw_pkg::ACRW_ACQUIRE:
        if (trigger) next_state = acrw_pkg::ACRW_ACQUIRE;
        else if (timer == 16'h0000) next_state = acrw_pkg::ACRW_CONVERT;
      acrw_pkg::ACRW_CONVERT:
        if (timer == 16'h0000) next_state = acrw_pkg::ACRW_IDLE;
      default: next_state = acrw_pkg::ACRW_IDLE;
    endcase
  end

  // Timer counts acquisition first, then conversion
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= acrw_pkg::ACRW_IDLE;
      timer <= 16'h0000;
    end else begin
      state <= next_state;
      if (trigger && state != acrw_pkg::ACRW_CONVERT) begin
        timer <= 16'(ACQ_CYCLES - 1);                        // [RQ9]
      end else if (acq_done) begin
        timer <= 16'(CONV_CYCLES - 1);
      end else if (timer != 16'h0000) begin
        timer <= timer - 16'h0001;
      end
    end
  end

  // Hold begins the cycle after the delay runs out
  assign acq_done = state == acrw_pkg::ACRW_ACQUIRE
                    && next_state == acrw_pkg::ACRW_CONVERT;

  // Registered status and start pulse
  always_ff @(posedge mclk) begin
    if (rst) begin
      conv_start <= 1'b0;
      track_hold <= 1'b0;
      conv_busy  <= 1'b0;
    end else begin
      conv_start <= acq_done;                                // [RQ9]
      track_hold <= next_state == acrw_pkg::ACRW_CONVERT;
      conv_busy  <= next_state != acrw_pkg::ACRW_IDLE;
    end
  end

  // Two's complement is offset binary with the top bit flipped
  // Straight binary passes the raw code through untouched
  always_ff @(posedge mclk) begin
    if (rst) begin
      coded_result <= 12'h000;
    end else begin
      coded_result <= {raw_result[11] ^ ctrl.twos_comp,
                       raw_result[10:0]};                    // [RQ8]
    end
  end
endmodule

// ===== verif/acrw_host.sv
// Host model writing the control register on both paths
`timescale 1ns/1ps
module acrw_host (
  input  wire logic  mclk,                      // Clock
  output logic       chip_sel_n         = 1'b1, // Select
  output logic       write_n            = 1'b1, // Strobe
  output logic [5:0] par_data           = 6'h00, // Data
  output logic       serial_clk         = 1'b1, // Idles high
  output logic       write_frame_sync_n = 1'b1, // Frame
  output logic       serial_din         = 1'b0  // Serial data
);
  // Strobe held three cycles; data scrambled after release
  task automatic par_wr(input logic [5:0] w);
    {chip_sel_n, write_n, par_data} = {2'b00, w};
    repeat (3) @(negedge mclk);
    {chip_sel_n, write_n, par_data} = {2'b11, ~w};
  endtask
  // MSB first; under six clocks the frame is an abort
  task automatic ser_wr(input logic [7:0] w, input int n);
    write_frame_sync_n = 1'b0;
    #1; // Keeps serial edges off the sampling clock edge
    for (int i = 0; i < n; i++) begin
      serial_din = w[7-i];
      #62.5 serial_clk = 1'b0;
      #62.5 serial_clk = 1'b1;
    end
    #62.5 write_frame_sync_n = 1'b1;
    serial_din = ~serial_din; // No stale bit once released
  endtask
endmodule

// ===== verif/acrw_ctrl_properties.sv
// Checker for the conversion control register block
`timescale 1ns/1ps
module acrw_ctrl_properties #(
  parameter int ACQ_CYCLES  = 40,
  parameter int CONV_CYCLES = 160
) (
  input wire logic        mclk,               // Clock
  input wire logic        rst,                // Reset
  input wire logic        write_n,            // Strobe
  input wire logic        write_frame_sync_n, // Frame
  input wire acrw_pkg::acrw_ctrl_s ctrl,      // Register
  input wire logic        track_hold,         // Hold
  input wire logic        conv_busy,          // Busy
  input wire logic        conv_start          // Start
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Pins quiet long enough for any write to have landed
  sequence quiet_s;
    (write_n && write_frame_sync_n) [*8];
  endsequence
  sequence launch_s;
    conv_start ##[0:1] track_hold;
  endsequence
  AST_RESET_ZERO: assert property ($fell(rst) |-> ctrl == 6'h00)
    else $error("register not cleared");
  AST_QUIET_KEEP: assert property (quiet_s |=> $stable(ctrl))
    else $error("register moved without write");
  AST_PULSE: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  AST_LAUNCH: assert property (conv_start |-> launch_s)
    else $error("no hold after start");
  AST_ACQ: assert property ($rose(conv_busy) |-> !conv_start [*8])
    else $error("start before acquisition");
  AST_HOLD_BUSY: assert property (track_hold |-> conv_busy)
    else $error("hold while idle");
  AST_HOLD_LEN: assert property ($fell(track_hold) |->
    $past(track_hold, CONV_CYCLES - 2) && !$past(track_hold, CONV_CYCLES + 2))
    else $error("hold length wrong");
  AST_CAUSE: assert property (conv_start |-> $past(conv_busy))
    else $error("start without acquisition");
endmodule
bind acrw_ctrl acrw_ctrl_properties #(.ACQ_CYCLES(ACQ_CYCLES),
  .CONV_CYCLES(CONV_CYCLES)) chk_i (.mclk, .rst, .write_n,
  .write_frame_sync_n, .ctrl, .track_hold, .conv_busy, .conv_start);

// ===== verif/acrw_ctrl_tb.sv
// Self-checking bench for the control register block
`timescale 1ns/1ps
module acrw_ctrl_tb;
  localparam int ACQ = 10, CONV = 20;
  logic mclk = 1'b0, rst = 1'b1, track_hold, conv_busy, conv_start;
  logic chip_sel_n, write_n, serial_clk, write_frame_sync_n, serial_din;
  logic [5:0] par_data;
  logic [11:0] raw_result = 12'h123, coded_result;
  acrw_pkg::acrw_ctrl_s ctrl;
  int num_errors = 0, checks_done = 0, n;
  acrw_host host (.mclk, .chip_sel_n, .write_n, .par_data, .serial_clk,
    .write_frame_sync_n, .serial_din);
  acrw_ctrl #(.ACQ_CYCLES(ACQ), .CONV_CYCLES(CONV)) uut (.mclk, .rst,
    .chip_sel_n, .write_n, .par_data, .serial_clk, .write_frame_sync_n,
    .serial_din, .raw_result, .ctrl, .coded_result, .track_hold,
    .conv_busy, .conv_start);
  // Free-running clock
  initial forever #5 mclk = ~mclk;
  // Word compare, for the coded result
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t: %h not %h", $time, got, exp);
    end
  endtask
  // Register compare, fields as packed
  task automatic chk_reg(input logic [5:0] got, input logic [5:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t: register %h not %h", $time, got, exp);
    end
  endtask
  // Single-bit status compare
  task automatic chk_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t: flag %b not %b", $time, got, exp);
    end
  endtask
  task automatic end_of_test(input int hung);
    num_errors += hung;
    $display("%0d checks, %0d errors", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Bounded wait; n ends as the cycles spent
  task automatic wait_start();
    for (n = 0; conv_start !== 1'b1; n++) begin
      @(negedge mclk);
      if (n > 300) end_of_test(1);
    end
  endtask
  // Register and status clear once the first reset lifts
  task automatic t_power_on();
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    chk_reg(ctrl, 6'h00);
    chk_flag(conv_busy, 1'b0);
    $display("power-on test done");
  endtask
  task automatic t_write();
    host.par_wr(6'h2b);
    repeat (8) @(negedge mclk);
    chk_reg(ctrl, 6'h2b);
    chk(coded_result, 12'h923);
    host.ser_wr(8'hab, 8);
    repeat (8) @(negedge mclk);
    chk_reg(ctrl, 6'h2a);
    chk(coded_result, 12'h123);
    host.ser_wr(8'h00, 5);
    repeat (8) @(negedge mclk);
    chk_reg(ctrl, 6'h2a);
    chk_flag(conv_busy, 1'b0);
    $display("write test done");
  endtask
  task automatic t_conv();
    host.par_wr(6'h0c);
    wait_start();
    chk_flag(n >= ACQ && n <= ACQ + 8, 1'b1);
    chk_flag(track_hold, 1'b1);
    repeat (CONV + 8) @(negedge mclk);
    chk_flag(conv_busy, 1'b0);
    host.ser_wr(8'hff, 2);
    wait_start();
    chk_reg(ctrl, 6'h0c);
    chk_flag(n >= ACQ && n <= ACQ + 8, 1'b1);
    repeat (CONV + ACQ + 8) @(negedge mclk);
    $display("conversion test done");
  endtask
  // Reset in mid-acquisition clears the register and drops the start
  task automatic t_reset();
    host.par_wr(6'h3f);
    repeat (8) @(negedge mclk);
    chk_flag(conv_busy, 1'b1);
    rst = 1'b1;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    chk_reg(ctrl, 6'h00);
    chk_flag(conv_busy, 1'b0);
    repeat (ACQ + 8) @(negedge mclk);
    chk_flag(conv_busy, 1'b0);
    $display("reset test done");
  endtask
  // Reset for twelve cycles, then the scenarios
  initial begin
    t_power_on();
    t_write();
    t_conv();
    t_reset();
    end_of_test(0);
  end
endmodule
